// ===== dv/lfb_host_model.sv
// host bus controller model driving frame and nibbles, logging the device
`default_nettype none
module lfb_host_model (
  // bus clock
  input wire logic clk_in,
  // device side of the nibble lines
  input wire logic [3:0] dev_lad_in,
  input wire logic dev_oe_in,
  // frame and resolved wire
  output logic frame_n_out,
  output logic [3:0] lad_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv_en; // host drives the lines
  logic [3:0] drv_nib; // host nibble
  logic [4:0] log_q [1:19]; // per cycle {device oe, device nibble}
  // wire level: device, else host, else pull-up
  assign lad_out = dev_oe_in ? dev_lad_in : (drv_en ? drv_nib : 4'hf);
  initial begin
    frame_n_out = 1'b1;
    drv_en = 1'b0;
    drv_nib = 4'hf;
  end
  // one host cycle, frame pulled low again at stop to abort
  task automatic run(input logic [3:0] typ, input logic [31:0] addr,
                     input logic [7:0] wdata, input int stop);
    int n;
    logic wr;
    wr = typ[1];
    n = wr ? 17 : 19;
    for (int c = 1; c <= n; c++) begin
      @(negedge clk_in);
      frame_n_out = !(c == 1 || c == stop);
      if (c == 1) drv_nib = 4'h0;
      else if (c == 2) drv_nib = typ;
      else if (c <= 10) drv_nib = addr[4*(10-c)+:4];
      else if (wr && c == 11) drv_nib = wdata[3:0];
      else if (wr && c == 12) drv_nib = wdata[7:4];
      else drv_nib = 4'hf;
      // released after its turnaround or after an abort
      drv_en = c <= (wr ? 13 : 11) && !(stop != 0 && c > stop);
      // device outputs settled at the previous rise
      log_q[c] = {dev_oe_in, dev_lad_in};
    end
    frame_n_out = 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== dv/test_lfb_bus_target.sv
// self-checking bench for the flash target bus logic
`default_nettype none
module test_lfb_bus_target;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [3:0] typ;
    logic [31:0] addr;
    logic [7:0] wdata;
    logic ok;
  } lfb_row_t;
  logic clk = 1'b0, rst_n = 1'b0, irst_n = 1'b1, crst_n = 1'b1;
  logic frame_n, tbl_n = 1'b1, wp_n = 1'b1, oe, rd_req, wr_req, arr, top;
  logic standby, in_rst, lock_def, pe_abort;
  logic [3:0] lad_wire, lad_dev;
  logic [7:0] lock = 8'h00, prot, wdat, rdat = 8'h00;
  logic [2:0] blk;
  logic [31:0] raddr;
  int tests_run = 0, bad_count = 0, rd_cnt = 0, wr_cnt = 0;
  int pe_cnt = 0, ld_cnt = 0;
  lfb_row_t rows [8] = '{
    '{4'h4, 32'hffc3_0012, 8'h00, 1'b1}, '{4'h4, 32'hff87_00a5, 8'h00, 1'b1},
    '{4'h4, 32'hfff7_ff5c, 8'h00, 1'b1}, '{4'h6, 32'hffc1_0034, 8'h3c, 1'b1},
    '{4'h7, 32'hff80_0001, 8'ha5, 1'b1}, '{4'hc, 32'hffc0_0000, 8'h00, 1'b0},
    '{4'h4, 32'hff40_0000, 8'h00, 1'b0}, '{4'h4, 32'h7fc0_0000, 8'h00, 1'b0}};
  always #20 clk = ~clk;
  lfb_bus_target i_lfb_bus_target (.ref_clk_in(clk), .reset_n_in(rst_n),
    .interface_reset_n_in(irst_n), .cpu_reset_n_in(crst_n),
    .frame_n_in(frame_n), .lad_in(lad_wire), .lad_out(lad_dev),
    .lad_oe_out(oe), .top_block_lock_n_in(tbl_n),
    .write_protect_n_in(wp_n), .lock_in(lock), .protect_out(prot),
    .rd_req_out(rd_req), .wr_req_out(wr_req), .req_addr_out(raddr),
    .req_array_out(arr), .block_sel_out(blk), .top_block_out(top),
    .wr_data_out(wdat), .rd_data_in(rdat), .standby_out(standby),
    .in_reset_out(in_rst), .lock_default_out(lock_def),
    .pe_abort_out(pe_abort));
  lfb_host_model i_lfb_host_model (.clk_in(clk), .dev_lad_in(lad_dev),
    .dev_oe_in(oe), .frame_n_out(frame_n), .lad_out(lad_wire));
  // memory side byte pattern keyed by the address
  function automatic logic [7:0] mem_byte(input logic [31:0] a);
    return a[7:0] ^ {a[22], a[18:16], 4'h3};
  endfunction
  always @(negedge clk) rdat <= mem_byte(raddr);
  // pulse counters, sampled mid-cycle
  always @(negedge clk) begin
    rd_cnt += (rd_req === 1'b1);
    wr_cnt += (wr_req === 1'b1);
    pe_cnt += (pe_abort === 1'b1);
    ld_cnt += (lock_def === 1'b1);
  end
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // expected {oe, nibble} per wire cycle; nibble 0 while floated
  function automatic logic [4:0] exp_log(input logic ok, input logic rd,
                                         input int c, input logic [7:0] d);
    if (!ok) return 5'h00;
    if (rd) case (c)
      13, 14: return 5'h15;
      15: return 5'h10;
      16: return {1'b1, d[3:0]};
      17: return {1'b1, d[7:4]};
      18: return 5'h1f;
      default: return 5'h00;
    endcase
    case (c)
      15: return 5'h10;
      16: return 5'h1f;
      default: return 5'h00;
    endcase
  endfunction
  // one whole bus cycle with all its checks
  task automatic run_row(input lfb_row_t r);
    int rd0, wr0;
    logic [4:0] s, e;
    rd0 = rd_cnt;
    wr0 = wr_cnt;
    i_lfb_host_model.run(r.typ, r.addr, r.wdata, 0);
    for (int c = 1; c <= (r.typ[1] ? 17 : 19); c++) begin
      s = i_lfb_host_model.log_q[c];
      e = exp_log(r.ok, !r.typ[1], c, mem_byte(r.addr));
      check("wire", 32'(s[4] ? s : {s[4], 4'h0}), 32'(e));
    end
    check("rd_req", 32'(rd_cnt - rd0), 32'(r.ok && !r.typ[1]));
    check("wr_req", 32'(wr_cnt - wr0), 32'(r.ok && r.typ[1]));
    check("standby", 32'(standby), 32'h1);
    if (r.ok) begin
      check("addr", raddr, r.addr);
      check("array", 32'(arr), 32'(r.addr[22]));
      check("block", 32'(blk), 32'(r.addr[18:16]));
      check("top", 32'(top), 32'(r.addr[18:16] == 3'h7));
      if (r.typ[1]) check("wdata", 32'(wdat), 32'(r.wdata));
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog, far beyond the expected few hundred cycles
  initial begin
    #200000;
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (3) @(negedge clk);
    check("oe rst", 32'(oe), 32'h0);
    check("prot rst", 32'(prot), 32'hff);
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    foreach (rows[i]) run_row(rows[i]);
    // forcing pins over the lock state
    for (int i = 0; i < 4; i++) begin
      lock = 8'h12;
      tbl_n = i[0];
      wp_n = i[1];
      repeat (2) @(negedge clk);
      check("prot", 32'(prot), 32'(lock | {~tbl_n, {7{~wp_n}}}));
    end
    tbl_n = 1'b1;
    wp_n = 1'b1;
    // abort in the wait syncs of a read
    i_lfb_host_model.run(4'h4, rows[0].addr, 8'h00, 14);
    check("abort oe", 32'(i_lfb_host_model.log_q[15][4]), 32'h0);
    // abort after a write's data: command still issued
    ld_cnt = wr_cnt;
    i_lfb_host_model.run(4'h6, rows[3].addr, 8'h77, 15);
    check("wr abort", 32'(wr_cnt - ld_cnt), 32'h1);
    check("wr oe", 32'(i_lfb_host_model.log_q[16][4]), 32'h0);
    // each device reset pin in mid read
    for (int k = 0; k < 2; k++) begin
      pe_cnt = 0;
      ld_cnt = 0;
      fork
        i_lfb_host_model.run(4'h4, rows[0].addr, 8'h00, 0);
        begin
          repeat (14) @(negedge clk);
          if (k == 0) irst_n = 1'b0;
          else crst_n = 1'b0;
        end
      join
      check("rst oe", 32'(i_lfb_host_model.log_q[15][4]), 32'h0);
      check("in_reset", 32'(in_rst), 32'h1);
      check("pe_abort", 32'(pe_cnt), 32'h1);
      irst_n = 1'b1;
      crst_n = 1'b1;
      repeat (3) @(negedge clk);
      check("lock_def", 32'(ld_cnt), 32'h1);
      check("out rst", 32'(in_rst), 32'h0);
      run_row(rows[2]);
    end
    finish_test();
  end
endmodule
`default_nettype wire

// ===== src/lfb_bus_target.sv
// low pin count flash target: cycle decode, sync, data and protection
`default_nettype none
`include "lfb_defs.svh"
module lfb_bus_target #(
  parameter int NUM_BLOCKS = `LFB_NUM_BLOCKS // uniform array blocks
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // device reset pins, low active
  input wire logic interface_reset_n_in,
  input wire logic cpu_reset_n_in,
  // bus frame and nibble lines
  input wire logic frame_n_in,
  input wire logic [3:0] lad_in,
  output logic [3:0] lad_out,
  output logic lad_oe_out,
  // protection pins and lock register state
  input wire logic top_block_lock_n_in,
  input wire logic write_protect_n_in,
  input wire logic [NUM_BLOCKS-1:0] lock_in,
  output logic [NUM_BLOCKS-1:0] protect_out,
  // request to the memory side
  output logic rd_req_out,
  output logic wr_req_out,
  output logic [31:0] req_addr_out,
  output logic req_array_out,
  output logic [2:0] block_sel_out,
  output logic top_block_out,
  output logic [7:0] wr_data_out,
  input wire logic [7:0] rd_data_in,
  // mode and reset status
  output logic standby_out,
  output logic in_reset_out,
  output logic lock_default_out,
  output logic pe_abort_out
);
  logic rst_n; // synchronised reset
  lfb_pkg::lfb_state_t state; // current cycle phase
  lfb_pkg::lfb_state_t next_state; // phase for next clock
  logic [2:0] cnt; // clocks spent in current phase
  logic [31:0] addr; // address shift register
  logic [31:0] next_addr; // address with this nibble added
  logic is_write; // direction of current cycle
  logic [7:0] rd_byte; // read byte held for return
  logic dev_reset; // either device reset pin low
  logic dev_reset_q; // previous value of dev_reset
  logic abort; // frame dropped inside a cycle
  logic type_ok; // type nibble decodes to read or write
  logic addr_ok; // fixed upper address bits all ones

  // reset release through two flops
  lfb_reset_sync u_rst (
    .clk_in(ref_clk_in),
    .rst_n_in(reset_n_in),
    .rst_n_out(rst_n)
  );

  // decode helpers
  assign dev_reset = !interface_reset_n_in || !cpu_reset_n_in;
  assign abort = !frame_n_in && state != lfb_pkg::ST_IDLE &&
                 state != lfb_pkg::ST_TYPE;
  assign next_addr = {addr[27:0], lad_in};
  assign addr_ok = next_addr[31:23] == `LFB_UPPER_ONES;
  // read 0100b or write 011Xb
  assign type_ok = lad_in[3:2] == `LFB_TYPE_HI &&
                   (lad_in[1] || !lad_in[0]);

  // phase sequencing
  always_comb begin
    next_state = state;
    if (dev_reset) begin
      next_state = lfb_pkg::ST_IDLE;
    end else if (abort) begin
      // drop cycle; a fresh start may ride the same edge
      next_state = (lad_in == `LFB_START_NIB) ? lfb_pkg::ST_TYPE :
                   lfb_pkg::ST_IDLE;
    end else begin
      unique case (state)
        lfb_pkg::ST_IDLE: begin
          if (!frame_n_in && lad_in == `LFB_START_NIB) begin
            next_state = lfb_pkg::ST_TYPE;
          end
        end
        lfb_pkg::ST_TYPE: begin
          if (!frame_n_in) begin
            // start field repeated or foreign start
            next_state = (lad_in == `LFB_START_NIB) ? lfb_pkg::ST_TYPE :
                         lfb_pkg::ST_IDLE;
          end else if (type_ok) begin
            next_state = lfb_pkg::ST_ADDR;
          end else begin
            next_state = lfb_pkg::ST_IDLE;
          end
        end
        lfb_pkg::ST_ADDR: begin
          if (cnt == `LFB_ADDR_LAST) begin
            if (!addr_ok) begin
              next_state = lfb_pkg::ST_IDLE;
            end else if (is_write) begin
              next_state = lfb_pkg::ST_WDATA;
            end else begin
              next_state = lfb_pkg::ST_HTAR;
            end
          end
        end
        lfb_pkg::ST_WDATA: begin
          if (cnt == `LFB_PAIR_LAST) begin
            next_state = lfb_pkg::ST_HTAR;
          end
        end
        lfb_pkg::ST_HTAR: begin
          next_state = lfb_pkg::ST_DTAR;
        end
        lfb_pkg::ST_DTAR: begin
          // write skips wait states
          next_state = is_write ? lfb_pkg::ST_SYNC :
                       lfb_pkg::ST_WAIT;
        end
        lfb_pkg::ST_WAIT: begin
          if (cnt == `LFB_PAIR_LAST) begin
            next_state = lfb_pkg::ST_SYNC;
          end
        end
        lfb_pkg::ST_SYNC: begin
          next_state = is_write ? lfb_pkg::ST_ETAR :
                       lfb_pkg::ST_RDATA;
        end
        lfb_pkg::ST_RDATA: begin
          if (cnt == `LFB_PAIR_LAST) begin
            next_state = lfb_pkg::ST_ETAR;
          end
        end
        lfb_pkg::ST_ETAR: begin
          next_state = lfb_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // phase register and phase clock counter
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= lfb_pkg::ST_IDLE;
      cnt <= 3'h0;
    end else begin
      state <= next_state;
      cnt <= (next_state != state) ? 3'h0 : cnt + 3'h1;
    end
  end

  // direction and address capture
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      is_write <= 1'b0;
      addr <= 32'h0;
    end else begin
      if (state == lfb_pkg::ST_TYPE && frame_n_in) begin
        is_write <= lad_in[1];
      end
      if (state == lfb_pkg::ST_ADDR) begin
        addr <= next_addr;
      end
    end
  end

  // request to memory side, issued after decode
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_req_out <= 1'b0;
      req_addr_out <= 32'h0;
      req_array_out <= 1'b0;
      block_sel_out <= 3'h0;
      top_block_out <= 1'b0;
    end else begin
      // read request as the host turnaround begins
      rd_req_out <= state == lfb_pkg::ST_ADDR &&
                    next_state == lfb_pkg::ST_HTAR && !is_write;
      if (state == lfb_pkg::ST_ADDR && cnt == `LFB_ADDR_LAST) begin
        req_addr_out <= next_addr;
        req_array_out <= next_addr[`LFB_ARRAY_BIT];
        block_sel_out <= next_addr[`LFB_BLK_LSB +: 3];
        top_block_out <= next_addr[`LFB_BLK_LSB +: 3] ==
                         `LFB_TOP_BLOCK;
      end
    end
  end

  // write byte assembly and command hand-off
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wr_data_out <= 8'h0;
      wr_req_out <= 1'b0;
    end else begin
      if (state == lfb_pkg::ST_WDATA && !abort && !dev_reset) begin
        if (cnt == 3'h0) begin
          wr_data_out[3:0] <= lad_in;
        end else begin
          wr_data_out[7:4] <= lad_in;
        end
      end
      // issued at once; a late abort cannot recall it
      wr_req_out <= state == lfb_pkg::ST_WDATA &&
                    next_state == lfb_pkg::ST_HTAR;
    end
  end

  // read byte taken as the wait states end
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rd_byte <= 8'h0;
    end else if (state == lfb_pkg::ST_WAIT &&
                 next_state == lfb_pkg::ST_SYNC) begin
      rd_byte <= rd_data_in;
    end
  end

  // line drivers follow the coming phase
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      lad_out <= `LFB_TAR_NIB;
      lad_oe_out <= 1'b0;
    end else begin
      lad_oe_out <= 1'b1;
      unique case (next_state)
        lfb_pkg::ST_WAIT: lad_out <= `LFB_SHORT_WAIT_SYNC;
        lfb_pkg::ST_SYNC: lad_out <= `LFB_READY_SYNC;
        lfb_pkg::ST_RDATA: begin
          // low nibble first
          lad_out <= (state == lfb_pkg::ST_SYNC) ? rd_byte[3:0] :
                     rd_byte[7:4];
        end
        lfb_pkg::ST_ETAR: lad_out <= `LFB_TAR_NIB;
        default: begin
          // float in all host phases, idle, abort and reset
          lad_out <= `LFB_TAR_NIB;
          lad_oe_out <= 1'b0;
        end
      endcase
    end
  end

  // reset, standby and program abort status
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      dev_reset_q <= 1'b0;
      in_reset_out <= 1'b0;
      lock_default_out <= 1'b0;
      pe_abort_out <= 1'b0;
      standby_out <= 1'b1;
    end else begin
      dev_reset_q <= dev_reset;
      in_reset_out <= dev_reset;
      lock_default_out <= dev_reset_q && !dev_reset;
      pe_abort_out <= dev_reset && !dev_reset_q;
      standby_out <= next_state == lfb_pkg::ST_IDLE;
    end
  end

  // per-block forced protection
  genvar b;
  generate
    for (b = 0; b < NUM_BLOCKS; b++) begin : g_prot
      always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          protect_out[b] <= 1'b1;
        end else if (b == NUM_BLOCKS - 1) begin
          protect_out[b] <= lock_in[b] || !top_block_lock_n_in;
        end else begin
          protect_out[b] <= lock_in[b] || !write_protect_n_in;
        end
      end
    end
  endgenerate

  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n);

  // device read answer after it takes the lines
  sequence s_rd_answer;
    (lad_oe_out && lad_out == `LFB_SHORT_WAIT_SYNC) [*2]
    ##1 (lad_oe_out && lad_out == `LFB_READY_SYNC)
    ##1 lad_oe_out [*2]
    ##1 (lad_oe_out && lad_out == `LFB_TAR_NIB) ##1 !lad_oe_out;
  endsequence
  // device write answer
  sequence s_wr_answer;
    (lad_oe_out && lad_out == `LFB_READY_SYNC)
    ##1 (lad_oe_out && lad_out == `LFB_TAR_NIB) ##1 !lad_oe_out;
  endsequence

  AST_START: assert property (
    state == lfb_pkg::ST_IDLE && !frame_n_in &&
    lad_in == `LFB_START_NIB && !dev_reset |=> state == lfb_pkg::ST_TYPE)
    else $error("start field not taken");
  AST_RD_TAIL: assert property (
    disable iff (!rst_n || dev_reset || !frame_n_in)
    rd_req_out |-> !lad_oe_out ##1 !lad_oe_out ##1 s_rd_answer)
    else $error("read answer sequence wrong");
  AST_RD_DATA: assert property (
    disable iff (!rst_n || dev_reset || !frame_n_in)
    state == lfb_pkg::ST_SYNC && !is_write |=>
    lad_out == rd_byte[3:0] ##1 lad_out == rd_byte[7:4])
    else $error("read nibble order wrong");
  AST_WR_TAIL: assert property (
    disable iff (!rst_n || dev_reset || !frame_n_in)
    wr_req_out |-> !lad_oe_out ##1 !lad_oe_out ##1 s_wr_answer)
    else $error("write answer sequence wrong");
  AST_WR_REQ: assert property (
    state == lfb_pkg::ST_WDATA && cnt == `LFB_PAIR_LAST &&
    frame_n_in && !dev_reset |=>
    wr_req_out && wr_data_out[7:4] == $past(lad_in))
    else $error("write command not issued");
  AST_ABORT: assert property (
    abort |=> !lad_oe_out && !rd_req_out && !wr_req_out)
    else $error("abort did not float lines");
  AST_STANDBY: assert property (
    state == lfb_pkg::ST_IDLE |-> !lad_oe_out && standby_out)
    else $error("idle without standby");
  AST_RESET: assert property (
    dev_reset |=> !lad_oe_out && state == lfb_pkg::ST_IDLE && in_reset_out)
    else $error("reset did not deselect");
  AST_LOCK: assert property (
    $fell(dev_reset) |=> lock_default_out ##1 !lock_default_out)
    else $error("lock default pulse missing");
  AST_PE_ABORT: assert property (
    $rose(dev_reset) |=> pe_abort_out)
    else $error("program abort not flagged");
  AST_PROTECT: assert property (
    !top_block_lock_n_in |=> protect_out[NUM_BLOCKS-1])
    else $error("top block not forced");
  AST_BAD_ADDR: assert property (
    frame_n_in && state == lfb_pkg::ST_ADDR && cnt == `LFB_ADDR_LAST &&
    !addr_ok |=> state == lfb_pkg::ST_IDLE && !rd_req_out && !lad_oe_out)
    else $error("bad address answered");
endmodule
`default_nettype wire

// ===== src/lfb_defs.svh
// constants for the low pin count flash target bus logic
`ifndef LFB_DEFS_SVH
`define LFB_DEFS_SVH
`define LFB_START_NIB 4'h0
`define LFB_TYPE_HI 2'h1
`define LFB_SHORT_WAIT_SYNC 4'h5
`define LFB_READY_SYNC 4'h0
`define LFB_TAR_NIB 4'hf
`define LFB_ADDR_LAST 3'h7
`define LFB_PAIR_LAST 3'h1
`define LFB_UPPER_ONES 9'h1ff
`define LFB_ARRAY_BIT 22
`define LFB_BLK_LSB 16
`define LFB_TOP_BLOCK 3'h7
`define LFB_NUM_BLOCKS 8
`endif

// ===== src/lfb_pkg.sv
// types for the low pin count flash target bus logic
`default_nettype none
package lfb_pkg;
  // bus cycle phases seen by the target
  typedef enum logic [3:0] {
    ST_IDLE, ST_TYPE, ST_ADDR, ST_WDATA, ST_HTAR,
    ST_DTAR, ST_WAIT, ST_SYNC, ST_RDATA, ST_ETAR
  } lfb_state_t;
endpackage
`default_nettype wire

// ===== src/lfb_reset_sync.sv
// two-flop release synchroniser for the asynchronous reset
`default_nettype none
module lfb_reset_sync (
  // clock and raw reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // synchronised reset
  output logic rst_n_out
);
  logic meta; // first stage, read only by second stage

  // assert at once, release after two edges
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta <= 1'b0;
      rst_n_out <= 1'b0;
    end else begin
      meta <= 1'b1;
      rst_n_out <= meta;
    end
  end
endmodule
`default_nettype wire
